// file: testbench.sv
// Self-checking testbench for the UART data path
`timescale 1ns/1ps
module testbench;
   logic       clk_sys;
   logic       rst_n;
   logic [2:0] bus_addr;
   logic       bus_wr;
   logic       bus_rd;
   logic [7:0] bus_wdata;
   logic [7:0] bus_rdata_q;
   logic       rx_in;
   logic       tx_out_q;
   logic       rx_ready_n_q;
   logic       tx_ready_n_q;
   int         errors = 0;
   int         cmp_count = 0;
   int         seed = 2;
   int         t0, t1, per, n;
   logic [7:0] line_control, d0, d1, r0, r1;
   logic       p0, p1, s0, s1;

   ufl_core #(.DEPTH(64), .AW(6)) ufl_core_i (
      .clk_sys(clk_sys), .rst_n(rst_n), .bus_addr(bus_addr), .bus_wr(bus_wr),
      .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata_q(bus_rdata_q), .rx_in(rx_in),
      .tx_out_q(tx_out_q), .rx_ready_n_q(rx_ready_n_q), .tx_ready_n_q(tx_ready_n_q));
   ufl_remote remote_i (.clk_sys(clk_sys), .tx_out_q(tx_out_q), .rx_in(rx_in));

   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask

   task automatic test_done();
      $display("errors %0d compares %0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(negedge clk_sys);
      bus_addr = a;
      bus_wdata = d;
      bus_wr = 1'b1;
      @(negedge clk_sys);
      bus_wr = 1'b0;
   endtask

   // Read data is registered, so it is taken one cycle after the strobe
   task automatic rchk(input logic [2:0] a, input logic [7:0] e);
      @(negedge clk_sys);
      bus_addr = a;
      bus_rd = 1'b1;
      @(negedge clk_sys);
      bus_rd = 1'b0;
      check(bus_rdata_q, e);
   endtask

   function automatic logic parity(input logic [7:0] d, input logic [7:0] l);
      logic [7:0] m;
      m = 8'hFF >> (2'd3 - l[1:0]);
      if (l[5]) return !l[4];
      return l[4] ? ^(d & m) : !(^(d & m));
   endfunction

   // Status is read before the character, never the other way round
   task automatic rx_case(input logic [7:0] d, input logic [7:0] l, input bit bp,
                          input bit bs, input logic [7:0] line_status);
      wr(3'h3, l);
      remote_i.send(d, 5 + l[1:0], l[3], parity(d, l) ^ bp, bs);
      rchk(3'h5, line_status);
      check(rx_ready_n_q, 1'b0);
      rchk(3'h0, d & (8'hFF >> (2'd3 - l[1:0])));
      repeat (2) @(negedge clk_sys);
      check(rx_ready_n_q, 1'b1);
   endtask

   initial begin
      #400000;
      errors++;
      test_done();
   end

   initial begin
      rst_n = 1'b0;
      bus_addr = 3'h0;
      bus_wr = 1'b0;
      bus_rd = 1'b0;
      bus_wdata = 8'h00;
      repeat (8) @(negedge clk_sys);
      rst_n = 1'b1;
      rchk(3'h5, 8'h60);
      rchk(3'h2, 8'h01);
      rchk(3'h3, 8'h03);
      rchk(3'h4, 8'h00);
      check(tx_ready_n_q, 1'b0);
      wr(3'h3, 8'h83);
      wr(3'h0, 8'h01);
      rchk(3'h0, 8'h01);
      rchk(3'h1, 8'h00);
      wr(3'h3, 8'h03);
      rchk(3'h1, 8'h00);
      for (int i = 0; i < 10; i++) begin
         line_control = {2'b00, 6'($random(seed))};
         d0 = 8'($random(seed));
         rx_case(d0, line_control, 1'b0, 1'b0, 8'h61);
      end
      rx_case(8'hA5, 8'h1B, 1'b1, 1'b0, 8'hE5);
      rchk(3'h5, 8'h60);
      rx_case(8'h6C, 8'h3B, 1'b1, 1'b0, 8'hE5);
      rx_case(8'h55, 8'h03, 1'b0, 1'b1, 8'hE9);
      rx_case(8'h00, 8'h03, 1'b0, 1'b1, 8'hF9);
      rchk(3'h5, 8'h60);
      // FIFOs off: a second unread character replaces the first
      remote_i.send(8'h11, 8, 1'b0, 1'b0, 1'b0);
      remote_i.send(8'h22, 8, 1'b0, 1'b0, 1'b0);
      rchk(3'h5, 8'h63);
      rchk(3'h5, 8'h61);
      rchk(3'h0, 8'h22);
      wr(3'h2, 8'h01);
      for (int i = 0; i < 3; i++) remote_i.send(8'h30 + 8'(i), 8, 1'b0, 1'b0, 1'b0);
      rchk(3'h5, 8'h61);
      rchk(3'h0, 8'h30);
      rchk(3'h0, 8'h31);
      wr(3'h2, 8'h03);
      rchk(3'h5, 8'h60);
      rchk(3'h2, 8'hC1);
      for (int i = 0; i < 6; i++) begin
         line_control = {2'b00, 6'($random(seed))};
         d0 = 8'($random(seed));
         d1 = 8'($random(seed));
         n = 5 + line_control[1:0];
         wr(3'h3, line_control);
         fork
            begin
               remote_i.recv(n, line_control[3], r0, p0, s0, t0);
               remote_i.recv(n, line_control[3], r1, p1, s1, t1);
            end
            begin
               wr(3'h0, d0);
               wr(3'h0, d1);
            end
         join
         check(r0, d0 & (8'hFF >> (2'd3 - line_control[1:0])));
         check(r1, d1 & (8'hFF >> (2'd3 - line_control[1:0])));
         check(p1, line_control[3] ? parity(d1, line_control) : 1'b0);
         check(s0 & s1, 1'b1);
         per = 16 * (1 + n + line_control[3]) + (line_control[2] ? (n == 5 ? 24 : 32) : 16);
         check((t1 - t0 >= per) && (t1 - t0 <= per + 2), 1'b1);
         repeat (40) @(negedge clk_sys);
         rchk(3'h5, 8'h60);
      end
      wr(3'h3, 8'h43);
      repeat (3) @(negedge clk_sys);
      check(tx_out_q, 1'b0);
      wr(3'h3, 8'h03);
      repeat (3) @(negedge clk_sys);
      check(tx_out_q, 1'b1);
      // DMA mode 1; TX trigger code stays at 8 spaces until enhanced enable is set
      wr(3'h2, 8'h39);
      repeat (12) wr(3'h0, 8'($random(seed)));
      repeat (2) @(negedge clk_sys);
      check(tx_ready_n_q, 1'b0);
      wr(3'h3, 8'hBF);
      wr(3'h2, 8'h10);
      wr(3'h3, 8'h03);
      // Flush keeps the shifter busy, so 54 or 55 spaces remain, under 56
      wr(3'h2, 8'h3D);
      repeat (12) wr(3'h0, 8'($random(seed)));
      repeat (2) @(negedge clk_sys);
      check(tx_ready_n_q, 1'b1);
      remote_i.send(8'h5A, 8, 1'b0, 1'b0, 1'b0);
      check(rx_ready_n_q, 1'b1);
      rchk(3'h5, 8'h01);
      wr(3'h2, 8'h00);
      rchk(3'h2, 8'h01);
      test_done();
   end
endmodule

// file: ufl_core.sv
// UART channel data path: FIFOs, shifters, line format and line status
//
// What this block does
// - Deserialize RX, push char plus flags to FIFO
// - FIFOs off: entry zero only, overwrite
// - Written bytes queue, then shift out on TX
// - FIFOs off: one FIFO byte plus two buffered, extras lost
// - FIFO control bit 0 enables both FIFOs
// - Bits 1 and 2 flush RX/TX, self-clear
// - FIFO control bit 3 picks DMA mode
// - TX trigger 8, 16, 32, 56 spaces
// - RX trigger 8, 16, 56, 60 characters
// - TX trigger writable only with enhanced enable
// - Line control 1:0 set 5 to 8 bits
// - Bit 2 gives 1, 1.5 or 2 stops
// - Bit 3 enables parity send and check
// - Bit 4 chooses odd or even parity
// - Bit 5 forces parity to inverse bit 4
// - Bit 6 holds TX low for break
// - Bit 7 maps divisor latch at shared addresses
// - Status bit 0 data ready, bit 1 overrun
// - Status 4:2 show head character's error flags
// - Status 5 holding empty, 6 all empty
// - Status 7 set while any stored error
// - Status read never pops the receive FIFO
// - Divisor bytes reachable only with bit 7
`timescale 1ns/1ps
`include "ufl_defs.svh"

module ufl_core #(
   parameter int DEPTH = 64,
   parameter int AW    = 6
) (
   // Clock and reset
   input  wire logic       clk_sys,
   input  wire logic       rst_n,
   // Host parallel bus
   input  wire logic [2:0] bus_addr,
   input  wire logic       bus_wr,
   input  wire logic       bus_rd,
   input  wire logic [7:0] bus_wdata,
   output logic      [7:0] bus_rdata_q,
   // Serial line
   input  wire logic       rx_in,
   output logic            tx_out_q,
   // DMA readiness, active low
   output logic            rx_ready_n_q,
   output logic            tx_ready_n_q
);

   localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);
   localparam logic [AW:0] ONE_C   = (AW+1)'(1);

   // Trigger level decode, transmit or receive table
   function automatic logic [AW:0] trig_level(input logic is_tx, input logic [1:0] code);
      logic [6:0] lv;
      lv = 7'h08;
      case (code)
         2'h0:    lv = 7'h08;
         2'h1:    lv = 7'h10;
         2'h2:    lv = is_tx ? 7'h20 : 7'h38;
         default: lv = is_tx ? 7'h38 : 7'h3C;
      endcase
      return (AW+1)'(lv);
   endfunction

   // Parity bit for a character under the current format
   function automatic logic par_of(input logic [7:0] line_control, input logic [7:0] d);
      logic p;
      p = line_control[`UFL_LCR_EVEN_BIT] ? ^d : ~^d;
      if (line_control[`UFL_LCR_FORCE_BIT])
         p = ~line_control[`UFL_LCR_EVEN_BIT];
      return p;
   endfunction

   // Control registers
   logic [7:0]  lcr_q;
   logic [7:0]  efr_q;
   logic [15:0] div_q;
   logic        fifo_en_q;
   logic        dma_mode_q;
   logic [1:0]  tx_trig_q;
   logic [1:0]  rx_trig_q;

   logic dlab;
   logic efr_acc;
   logic wr_thr;
   logic wr_fcr;
   logic rd_rhr;
   logic rd_lsr;
   logic [1:0] wlen;
   logic [2:0] wlast;

   assign dlab    = lcr_q[`UFL_LCR_DLAB_BIT];
   assign efr_acc = (lcr_q == `UFL_LCR_EFR_KEY);
   assign wr_thr  = bus_wr && bus_addr == `UFL_ADDR_DATA && !dlab;
   assign wr_fcr  = bus_wr && bus_addr == `UFL_ADDR_FIFO && !efr_acc;
   assign rd_rhr  = bus_rd && bus_addr == `UFL_ADDR_DATA && !dlab;
   assign rd_lsr  = bus_rd && bus_addr == `UFL_ADDR_STATUS;
   assign wlen    = lcr_q[`UFL_LCR_WLEN_LSB +: 2];
   assign wlast   = {1'b1, wlen};

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         lcr_q      <= `UFL_LCR_RST;
         efr_q      <= `UFL_EFR_RST;
         div_q      <= `UFL_DIV_RST;
         fifo_en_q  <= 1'b0;
         dma_mode_q <= 1'b0;
         tx_trig_q  <= 2'h0;
         rx_trig_q  <= 2'h0;
      end else if (bus_wr) begin
         if (bus_addr == `UFL_ADDR_LINE)
            lcr_q <= bus_wdata;
         if (bus_addr == `UFL_ADDR_FIFO && efr_acc)
            efr_q <= bus_wdata;
         if (bus_addr == `UFL_ADDR_DATA && dlab)
            div_q[7:0] <= bus_wdata;
         if (bus_addr == `UFL_ADDR_DIVHI && dlab)
            div_q[15:8] <= bus_wdata;
         if (wr_fcr) begin
            fifo_en_q  <= bus_wdata[`UFL_FCR_EN_BIT];
            dma_mode_q <= bus_wdata[`UFL_FCR_DMA_BIT];
            rx_trig_q  <= bus_wdata[`UFL_FCR_RXTRG_LSB +: 2];
            if (efr_q[`UFL_EFR_ENH_BIT])
               tx_trig_q <= bus_wdata[`UFL_FCR_TXTRG_LSB +: 2];
         end
      end
   end

   // Flush pulses exist only in the write cycle, so they clear themselves
   logic flush_rx;
   logic flush_tx;
   assign flush_rx = wr_fcr && bus_wdata[`UFL_FCR_RXCLR_BIT];
   assign flush_tx = wr_fcr && bus_wdata[`UFL_FCR_TXCLR_BIT];

   // 16x baud tick; divisor zero behaves as one
   logic [15:0] baud_cnt_q;
   logic        tick;
   assign tick = (baud_cnt_q == 16'h0000);

   always_ff @(posedge clk_sys) begin
      if (!rst_n)
         baud_cnt_q <= 16'h0000;
      else if (tick)
         baud_cnt_q <= (div_q == 16'h0000) ? 16'h0000 : div_q - 16'h0001;
      else
         baud_cnt_q <= baud_cnt_q - 16'h0001;
   end

   // Receive shifter
   ufl_pkg::ufl_rx_st_t rx_st_q;
   logic [3:0]  rx_os_q;
   logic [2:0]  rx_bit_q;
   logic [7:0]  rx_sh_q;
   logic        rx_zero_q;
   logic        rx_pe_q;
   logic        rx_push_q;
   logic [10:0] rx_word_q;

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         rx_st_q   <= ufl_pkg::RX_IDLE;
         rx_os_q   <= 4'h0;
         rx_bit_q  <= 3'h0;
         rx_sh_q   <= 8'h00;
         rx_zero_q <= 1'b0;
         rx_pe_q   <= 1'b0;
         rx_push_q <= 1'b0;
         rx_word_q <= 11'h000;
      end else begin
         rx_push_q <= 1'b0;
         if (tick) begin
            rx_os_q <= rx_os_q + 4'h1;
            case (rx_st_q)
               ufl_pkg::RX_IDLE: begin
                  rx_os_q <= 4'h0;
                  if (!rx_in)
                     rx_st_q <= ufl_pkg::RX_START;
               end
               ufl_pkg::RX_START: begin
                  // A glitch shorter than half a bit is not a start
                  if (rx_os_q == `UFL_OS_MID) begin
                     rx_os_q   <= 4'h0;
                     rx_bit_q  <= 3'h0;
                     rx_sh_q   <= 8'h00;
                     rx_zero_q <= 1'b1;
                     rx_pe_q   <= 1'b0;
                     rx_st_q   <= rx_in ? ufl_pkg::RX_IDLE : ufl_pkg::RX_DATA;
                  end
               end
               ufl_pkg::RX_DATA: begin
                  if (rx_os_q == `UFL_OS_LAST) begin
                     rx_sh_q[rx_bit_q] <= rx_in;
                     rx_zero_q         <= rx_zero_q & ~rx_in;
                     rx_bit_q          <= rx_bit_q + 3'h1;
                     if (rx_bit_q == wlast)
                        rx_st_q <= lcr_q[`UFL_LCR_PEN_BIT] ? ufl_pkg::RX_PAR
                                                           : ufl_pkg::RX_STOP;
                  end
               end
               ufl_pkg::RX_PAR: begin
                  if (rx_os_q == `UFL_OS_LAST) begin
                     rx_pe_q   <= rx_in != par_of(lcr_q, rx_sh_q);
                     rx_zero_q <= rx_zero_q & ~rx_in;
                     rx_st_q   <= ufl_pkg::RX_STOP;
                  end
               end
               ufl_pkg::RX_STOP: begin
                  if (rx_os_q == `UFL_OS_LAST) begin
                     rx_push_q <= 1'b1;
                     // Break: line low through stop, char stored as zero
                     rx_word_q <= {rx_zero_q & ~rx_in, ~rx_in, rx_pe_q, rx_sh_q};
                     rx_st_q   <= rx_in ? ufl_pkg::RX_IDLE : ufl_pkg::RX_WAIT;
                  end
               end
               ufl_pkg::RX_WAIT: begin
                  // One entry per break, not one per character time
                  if (rx_in)
                     rx_st_q <= ufl_pkg::RX_IDLE;
               end
               default: rx_st_q <= ufl_pkg::RX_IDLE;
            endcase
         end
      end
   end

   // Receive FIFO, entry {break, framing, parity, data}
   logic [10:0] rx_mem [DEPTH];
   logic [AW-1:0] rx_wp_q;
   logic [AW-1:0] rx_rp_q;
   logic [AW:0]   rx_cnt_q;
   logic [AW:0]   rx_err_q;
   logic          ovr_q;
   logic [10:0]   rx_head;
   logic          rx_pop;
   logic          rx_full;
   logic          rx_word_err;

   assign rx_head     = rx_mem[rx_rp_q];
   assign rx_pop      = rd_rhr && rx_cnt_q != '0;
   assign rx_full     = fifo_en_q ? (rx_cnt_q == DEPTH_C) : 1'b0;
   assign rx_word_err = |rx_word_q[10:8];

   always_ff @(posedge clk_sys) begin
      if (rx_push_q && !rx_full)
         rx_mem[fifo_en_q ? rx_wp_q : '0] <= rx_word_q;
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n || flush_rx) begin
         rx_wp_q  <= '0;
         rx_rp_q  <= '0;
         rx_cnt_q <= '0;
         rx_err_q <= '0;
      end else if (!fifo_en_q) begin
         if (rx_push_q) begin
            rx_wp_q  <= AW'(1);
            rx_rp_q  <= '0;
            rx_cnt_q <= ONE_C;
            rx_err_q <= rx_word_err ? ONE_C : '0;
         end else if (rx_pop) begin
            rx_rp_q  <= rx_rp_q + AW'(1);
            rx_cnt_q <= '0;
            rx_err_q <= '0;
         end
      end else begin
         if (rx_push_q && !rx_full)
            rx_wp_q <= rx_wp_q + AW'(1);
         if (rx_pop)
            rx_rp_q <= rx_rp_q + AW'(1);
         rx_cnt_q <= rx_cnt_q + ((rx_push_q && !rx_full) ? ONE_C : '0)
                              - (rx_pop ? ONE_C : '0);
         rx_err_q <= rx_err_q + ((rx_push_q && !rx_full && rx_word_err) ? ONE_C : '0)
                              - ((rx_pop && |rx_head[10:8]) ? ONE_C : '0);
      end
   end

   // Overrun: set wins over the clear by a status read
   always_ff @(posedge clk_sys) begin
      if (!rst_n)
         ovr_q <= 1'b0;
      else if (rx_push_q && (rx_full || (!fifo_en_q && rx_cnt_q != '0 && !rx_pop)))
         ovr_q <= 1'b1;
      else if (rd_lsr)
         ovr_q <= 1'b0;
   end

   // Transmit FIFO; with FIFOs off it holds a single byte
   logic [7:0]    tx_mem [DEPTH];
   logic [AW-1:0] tx_wp_q;
   logic [AW-1:0] tx_rp_q;
   logic [AW:0]   tx_cnt_q;
   logic          tx_push;
   logic          tx_pop;
   logic          buf_ready;

   assign tx_push = wr_thr && tx_cnt_q < (fifo_en_q ? DEPTH_C : ONE_C);
   assign tx_pop  = tx_cnt_q != '0 && buf_ready;

   always_ff @(posedge clk_sys) begin
      if (tx_push)
         tx_mem[tx_wp_q] <= bus_wdata;
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n || flush_tx) begin
         tx_wp_q  <= '0;
         tx_rp_q  <= '0;
         tx_cnt_q <= '0;
      end else begin
         if (tx_push)
            tx_wp_q <= tx_wp_q + AW'(1);
         if (tx_pop)
            tx_rp_q <= tx_rp_q + AW'(1);
         tx_cnt_q <= tx_cnt_q + (tx_push ? ONE_C : '0) - (tx_pop ? ONE_C : '0);
      end
   end

   // Two-entry buffer between FIFO and shifter; a full buffer stalls the FIFO
   logic [7:0] buf_mem [2];
   logic       buf_wp_q;
   logic       buf_rp_q;
   logic [1:0] buf_cnt_q;
   logic       buf_valid;
   logic       tsr_take;

   assign buf_ready = buf_cnt_q != 2'h2;
   assign buf_valid = buf_cnt_q != 2'h0;

   always_ff @(posedge clk_sys) begin
      if (tx_pop)
         buf_mem[buf_wp_q] <= tx_mem[tx_rp_q];
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n || flush_tx) begin
         buf_wp_q  <= 1'b0;
         buf_rp_q  <= 1'b0;
         buf_cnt_q <= 2'h0;
      end else begin
         if (tx_pop)
            buf_wp_q <= ~buf_wp_q;
         if (tsr_take)
            buf_rp_q <= ~buf_rp_q;
         buf_cnt_q <= buf_cnt_q + (tx_pop ? 2'h1 : 2'h0) - (tsr_take ? 2'h1 : 2'h0);
      end
   end

   // Transmit shifter
   ufl_pkg::ufl_tx_st_t tx_st_q;
   logic [4:0] tx_os_q;
   logic [2:0] tx_bit_q;
   logic [7:0] tx_sh_q;
   logic       tx_par_q;
   logic [7:0] tx_byte;
   logic [4:0] stop_len;

   assign tsr_take = (tx_st_q == ufl_pkg::TX_IDLE) && buf_valid;
   assign tx_byte  = buf_mem[buf_rp_q] & (8'hFF >> (2'h3 - wlen));
   assign stop_len = !lcr_q[`UFL_LCR_STOP_BIT] ? `UFL_STOP_1 :
                     (wlen == 2'h0) ? `UFL_STOP_15 : `UFL_STOP_2;

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         tx_st_q  <= ufl_pkg::TX_IDLE;
         tx_os_q  <= 5'h00;
         tx_bit_q <= 3'h0;
         tx_sh_q  <= 8'h00;
         tx_par_q <= 1'b0;
      end else if (tsr_take) begin
         tx_st_q  <= ufl_pkg::TX_START;
         tx_os_q  <= 5'h00;
         tx_bit_q <= 3'h0;
         tx_sh_q  <= tx_byte;
         tx_par_q <= par_of(lcr_q, tx_byte);
      end else if (tick && tx_st_q != ufl_pkg::TX_IDLE) begin
         tx_os_q <= tx_os_q + 5'h01;
         if (tx_os_q[3:0] == `UFL_OS_LAST && tx_st_q != ufl_pkg::TX_STOP) begin
            tx_os_q <= 5'h00;
            case (tx_st_q)
               ufl_pkg::TX_START: tx_st_q <= ufl_pkg::TX_DATA;
               ufl_pkg::TX_DATA: begin
                  tx_sh_q  <= tx_sh_q >> 1;
                  tx_bit_q <= tx_bit_q + 3'h1;
                  if (tx_bit_q == wlast)
                     tx_st_q <= lcr_q[`UFL_LCR_PEN_BIT] ? ufl_pkg::TX_PAR
                                                        : ufl_pkg::TX_STOP;
               end
               ufl_pkg::TX_PAR: tx_st_q <= ufl_pkg::TX_STOP;
               default:         tx_st_q <= ufl_pkg::TX_IDLE;
            endcase
         end else if (tx_st_q == ufl_pkg::TX_STOP && tx_os_q == stop_len - 5'h01) begin
            tx_st_q <= ufl_pkg::TX_IDLE;
         end
      end
   end

   // Serial output; break overrides the line but shifting continues
   logic tx_line;
   always_comb begin
      case (tx_st_q)
         ufl_pkg::TX_START: tx_line = 1'b0;
         ufl_pkg::TX_DATA:  tx_line = tx_sh_q[0];
         ufl_pkg::TX_PAR:   tx_line = tx_par_q;
         default:           tx_line = 1'b1;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n)
         tx_out_q <= 1'b1;
      else
         tx_out_q <= lcr_q[`UFL_LCR_BREAK_BIT] ? 1'b0 : tx_line;
   end

   // Line status
   logic       thr_empty;
   logic [7:0] line_status;
   assign thr_empty = tx_cnt_q == '0 && !buf_valid;
   assign line_status = {rx_err_q != '0,
                 thr_empty && tx_st_q == ufl_pkg::TX_IDLE,
                 thr_empty,
                 (rx_cnt_q != '0) ? rx_head[10:8] : 3'h0,
                 ovr_q,
                 rx_cnt_q != '0};

   // Read data, one cycle after the read strobe
   always_ff @(posedge clk_sys) begin
      if (!rst_n)
         bus_rdata_q <= 8'h00;
      else if (bus_rd) begin
         case (bus_addr)
            `UFL_ADDR_DATA:   bus_rdata_q <= dlab ? div_q[7:0] : rx_head[7:0];
            `UFL_ADDR_DIVHI:  bus_rdata_q <= dlab ? div_q[15:8] : 8'h00;
            `UFL_ADDR_FIFO:   bus_rdata_q <= efr_acc ? efr_q : {{2{fifo_en_q}}, 6'h01};
            `UFL_ADDR_LINE:   bus_rdata_q <= lcr_q;
            `UFL_ADDR_STATUS: bus_rdata_q <= line_status;
            default:          bus_rdata_q <= 8'h00;
         endcase
      end
   end

   // DMA readiness: mode 0 single-character, mode 1 trigger levels
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         rx_ready_n_q <= 1'b1;
         tx_ready_n_q <= 1'b1;
      end else if (dma_mode_q && fifo_en_q) begin
         rx_ready_n_q <= rx_cnt_q < trig_level(1'b0, rx_trig_q);
         tx_ready_n_q <= (DEPTH_C - tx_cnt_q) < trig_level(1'b1, tx_trig_q);
      end else begin
         rx_ready_n_q <= rx_cnt_q == '0;
         tx_ready_n_q <= tx_cnt_q != '0;
      end
   end

endmodule

// file: ufl_core_monitor.sv
// Port-level checker for the UART data path, bound to ufl_core
`timescale 1ns/1ps
module ufl_core_monitor #(
   parameter int DEPTH = 64,
   parameter int AW    = 6
) (
   // Clock and reset
   input wire logic       clk_sys,
   input wire logic       rst_n,
   // Host parallel bus
   input wire logic [2:0] bus_addr,
   input wire logic       bus_wr,
   input wire logic       bus_rd,
   input wire logic [7:0] bus_wdata,
   input wire logic [7:0] bus_rdata_q,
   // Serial line and DMA readiness
   input wire logic       rx_in,
   input wire logic       tx_out_q,
   input wire logic       rx_ready_n_q,
   input wire logic       tx_ready_n_q
);
   logic [7:0] lcr_q;
   logic       fen_q;

   // Shadows of written control state, so read-back can be judged from the pins
   always_ff @(posedge clk_sys) begin
      if (!rst_n)
         lcr_q <= 8'h03;
      else if (bus_wr && bus_addr == 3'h3)
         lcr_q <= bus_wdata;
   end
   always_ff @(posedge clk_sys) begin
      if (!rst_n)
         fen_q <= 1'b0;
      else if (bus_wr && bus_addr == 3'h2 && lcr_q != 8'hBF)
         fen_q <= bus_wdata[0];
   end

   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   AST_RESET_IDLE: assert property (
      $rose(rst_n) |-> tx_out_q && rx_ready_n_q && bus_rdata_q == 8'h00)
      else $error("outputs not idle after reset");
   AST_BREAK_LOW: assert property (
      lcr_q[6] && $past(lcr_q[6]) |-> !tx_out_q)
      else $error("tx line not held low during break");
   AST_START_WIDTH: assert property (
      $fell(tx_out_q) && !lcr_q[6] |-> (!tx_out_q) [*8])
      else $error("start bit shorter than half a bit");
   AST_TX_EMPTY_ORDER: assert property (
      bus_rd && bus_addr == 3'h5 && lcr_q != 8'hBF |=> !bus_rdata_q[6] || bus_rdata_q[5])
      else $error("all-empty flag set while holding not empty");
   AST_HEAD_ERR: assert property (
      bus_rd && bus_addr == 3'h5 && lcr_q != 8'hBF
      |=> bus_rdata_q[4:2] == 3'b000 || (bus_rdata_q[7] && bus_rdata_q[0]))
      else $error("head error flag without fifo error or data ready");
   AST_DIVHI_HIDDEN: assert property (
      bus_rd && bus_addr == 3'h1 && !lcr_q[7] |=> bus_rdata_q == 8'h00)
      else $error("divisor high byte visible without latch access");
   AST_FIFO_READBACK: assert property (
      bus_rd && bus_addr == 3'h2 && lcr_q != 8'hBF |=> bus_rdata_q[7:6] == {2{$past(fen_q)}})
      else $error("fifo enable mirror wrong");
   AST_NO_POP: assert property (
      (bus_rd && bus_addr == 3'h5) ##1 (bus_rdata_q[0] && !bus_rd && !bus_wr)
      ##1 (bus_rd && bus_addr == 3'h5) |=> bus_rdata_q[0])
      else $error("status read dropped a character");
endmodule

bind ufl_core ufl_core_monitor #(.DEPTH(DEPTH), .AW(AW)) mon_i (
   .clk_sys      (clk_sys),
   .rst_n        (rst_n),
   .bus_addr     (bus_addr),
   .bus_wr       (bus_wr),
   .bus_rd       (bus_rd),
   .bus_wdata    (bus_wdata),
   .bus_rdata_q  (bus_rdata_q),
   .rx_in        (rx_in),
   .tx_out_q     (tx_out_q),
   .rx_ready_n_q (rx_ready_n_q),
   .tx_ready_n_q (tx_ready_n_q)
);

// file: ufl_defs.svh
// Register offsets, field positions, reset values and timing counts for the UART data path
`ifndef UFL_DEFS_SVH
`define UFL_DEFS_SVH

// Register offsets on the 3-bit host address
`define UFL_ADDR_DATA      3'h0
`define UFL_ADDR_DIVHI     3'h1
`define UFL_ADDR_FIFO      3'h2
`define UFL_ADDR_LINE      3'h3
`define UFL_ADDR_STATUS    3'h5

// Line control fields
`define UFL_LCR_WLEN_LSB   0
`define UFL_LCR_STOP_BIT   2
`define UFL_LCR_PEN_BIT    3
`define UFL_LCR_EVEN_BIT   4
`define UFL_LCR_FORCE_BIT  5
`define UFL_LCR_BREAK_BIT  6
`define UFL_LCR_DLAB_BIT   7
`define UFL_LCR_EFR_KEY    8'hBF

// FIFO control fields
`define UFL_FCR_EN_BIT     0
`define UFL_FCR_RXCLR_BIT  1
`define UFL_FCR_TXCLR_BIT  2
`define UFL_FCR_DMA_BIT    3
`define UFL_FCR_TXTRG_LSB  4
`define UFL_FCR_RXTRG_LSB  6

// Enhanced feature control field
`define UFL_EFR_ENH_BIT    4

// Reset values
`define UFL_LCR_RST        8'h03
`define UFL_EFR_RST        8'h00
`define UFL_DIV_RST        16'h0001

// Timing in 16x baud ticks
`define UFL_OS_LAST        4'hF
`define UFL_OS_MID         4'h7
`define UFL_STOP_1         5'h10
`define UFL_STOP_15        5'h18
`define UFL_STOP_2         5'h20

`endif

// file: ufl_pkg.sv
// Types shared by the UART data path
package ufl_pkg;
   typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP, RX_WAIT} ufl_rx_st_t;
   typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} ufl_tx_st_t;
endpackage

// file: ufl_remote.sv
// Remote serial device: frames characters onto rx and decodes tx
`timescale 1ns/1ps
module ufl_remote (
   // Clock
   input wire logic clk_sys,
   // Serial line
   input wire logic tx_out_q,
   output logic     rx_in
);
   int cyc = 0;

   // Idle line is high; 16 clocks per bit at divisor one
   initial rx_in = 1'b1;
   always @(negedge clk_sys) cyc <= cyc + 1;

   task automatic bit_out(input logic v);
      @(negedge clk_sys);
      rx_in = v;
      repeat (15) @(negedge clk_sys);
   endtask

   task automatic send(input logic [7:0] d, input int n, input bit pen, input bit pb,
                       input bit bad_stop);
      bit_out(1'b0);
      for (int i = 0; i < n; i++) bit_out(d[i]);
      if (pen) bit_out(pb);
      bit_out(!bad_stop);
      bit_out(1'b1);
   endtask

   // Samples mid-bit; start time lets the caller measure frame length
   task automatic recv(input int n, input bit pen, output logic [7:0] d, output logic p,
                       output logic s, output int t0);
      d = 8'h00;
      p = 1'b0;
      @(negedge clk_sys);
      while (tx_out_q !== 1'b0) @(negedge clk_sys);
      t0 = cyc;
      repeat (8) @(negedge clk_sys);
      for (int i = 0; i < n; i++) begin
         repeat (16) @(negedge clk_sys);
         d[i] = tx_out_q;
      end
      if (pen) begin
         repeat (16) @(negedge clk_sys);
         p = tx_out_q;
      end
      repeat (16) @(negedge clk_sys);
      s = tx_out_q;
   endtask
endmodule
